// [psq_regs.vh]
// register offsets, field positions, reset values and timing counts
// for the phase 2 sequencer; definitions only, included by bare name
`ifndef PSQ_REGS_VH
`define PSQ_REGS_VH

// apb byte offsets
`define PSQ_CTRL_OFS      12'h000
`define PSQ_CFG_A_OFS     12'h004
`define PSQ_CFG_B_OFS     12'h008
`define PSQ_SERIAL_OFS    12'h00C
`define PSQ_STATUS_OFS    12'h010

// control field positions
`define PSQ_CTRL_START    0
`define PSQ_CTRL_SYNC     1
`define PSQ_CTRL_EXT      2
`define PSQ_CTRL_DIR_LO   4
`define PSQ_CTRL_RNG_LO   6

// reset values
`define PSQ_CTRL_RST      8'h00
`define PSQ_CFG_A_RST     32'h00000000
`define PSQ_CFG_B_RST     16'h0000
`define PSQ_SERIAL_RST    32'h00000000

// stream shape
`define PSQ_NIBBLES       6'h20
`define PSQ_K_ASYNC       4'h8
`define PSQ_K_SYNC        4'h4
`define PSQ_PROTO_REV     4'h4
`define PSQ_BLOCKS_HI     4'h2
`define PSQ_BLOCKS_LO     4'h0
`define PSQ_TYPE_HI       4'h0
`define PSQ_TYPE_LO       4'h1
`define PSQ_RANGE_BASE    4'h7

// timing
`define PSQ_CLK_PERIOD_NS 40
`define PSQ_ASYNC_PER_NS  228000
`define PSQ_SYNC_PER_NS   500000
`define PSQ_ASYNC_PER_CYC 13'h1644 // 228 us of 40 ns cycles

`endif

// [psq_init2_seq.v]
// phase 2 initialization stream sequencer, 10-bit data mode, with apb
// configuration registers. assumes one 25 MHz clock, an apb master on
// the same clock, a sync pulse arriving from a pin, and offset and
// self-test values from on-chip logic on the same clock.
//
// What this block does
// - each nibble sent as id then data
// - pairs repeated k times, nibbles ascending
// - asynchronous 228 us period uses k of 8
// - synchronous 500 us period uses k of 4
// - nibble one carries protocol revision 0100
// - nibbles two, three carry block count 0010 0000
// - nibbles six, seven carry sensor type 0000 0001
// - nibble eight encodes axis direction setting
// - nibble nine encodes full-scale range
// - nibbles fifteen to eighteen carry julian date
// - nibbles 27 to 31 carry offset, self-test
// - zeros there when extended data disabled
// - last nibble config one high or zero
// - zeros when self-test values not ready
// - extended enable selects offset, self-test insertion
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "psq_regs.vh"

module psq_init2_seq #(
   parameter [12:0] ASYNC_PERIOD_CYC = `PSQ_ASYNC_PER_CYC,
   parameter [3:0]  PROD_REV_HI      = 4'h1, // arbitrary factory value
   parameter [3:0]  PROD_REV_LO      = 4'h0  // arbitrary factory value
) (
   // clock and reset
   input  wire        CLK_IN,
   input  wire        RST_N_IN,
   // apb slave
   input  wire        PSEL_IN,
   input  wire        PENABLE_IN,
   input  wire        PWRITE_IN,
   input  wire [11:0] PADDR_IN,
   input  wire [31:0] PWDATA_IN,
   output wire [31:0] PRDATA_OUT,
   output wire        PREADY_OUT,
   output wire        PSLVERR_OUT,
   // sync pulse from the receiver, asynchronous pin
   input  wire        SYNC_PULSE_IN,
   // self-test results, same clock
   input  wire [9:0]  RAW_OFFSET_IN,
   input  wire        OFFSET_VALID_IN,
   input  wire [9:0]  AVG_SELFTEST_IN,
   input  wire        SELFTEST_VALID_IN,
   // transmission stream
   output reg         TX_VALID_OUT,
   output reg  [3:0]  TX_NIBBLE_OUT,
   output reg         TX_IS_ID_OUT,
   output reg         PHASE2_DONE_OUT
);

   // one-hot sequencer states
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_RUN  = 3'b010;
   localparam [2:0] ST_DONE = 3'b100;

   // configuration, bus and sequencer state
   reg [2:0]  state_q;
   reg [7:0]  ctrl_q;
   reg [31:0] cfg_a_q;
   reg [15:0] cfg_b_q;
   reg [31:0] serial_q;
   reg [31:0] prdata_q;
   reg        pslverr_q;
   reg        start_q;
   reg        sync_meta_q;
   reg        sync_s_q;
   reg        sync_prev_q;
   reg [12:0] timer_q;
   reg [4:0]  nib_q;
   reg [3:0]  rep_q;
   reg        is_data_q;
   reg [9:0]  tx_cnt_q;
   reg        run_sync_q;
   reg        run_ext_q;

   // control and configuration fields by role
   wire       sync_mode = ctrl_q[`PSQ_CTRL_SYNC];
   wire [1:0] dir_sel   = ctrl_q[`PSQ_CTRL_DIR_LO+1:`PSQ_CTRL_DIR_LO];
   wire [1:0] rng_sel   = ctrl_q[`PSQ_CTRL_RNG_LO+1:`PSQ_CTRL_RNG_LO];
   wire [7:0] maker_code_field  = cfg_a_q[7:0];
   wire [7:0] device_config_one = cfg_a_q[15:8];
   wire [7:0] device_config_two = cfg_a_q[23:16];
   wire [7:0] device_config_six = cfg_a_q[31:24];
   wire [7:0] device_config_seven = cfg_b_q[7:0];
   wire [7:0] device_config_eight = cfg_b_q[15:8];
   wire [7:0] serial_byte_zero  = serial_q[7:0];
   wire [7:0] serial_byte_one   = serial_q[15:8];
   wire [7:0] serial_byte_two   = serial_q[23:16];
   wire [7:0] serial_byte_three = serial_q[31:24];

   // julian date fields packed from config seven and eight
   wire [6:0] julian_year  = device_config_seven[6:0];
   wire [3:0] julian_month = {device_config_seven[7],
                              device_config_eight[7:5]};
   wire [4:0] julian_day   = device_config_eight[4:0];

   // apb decode, zero wait states
   wire apb_setup  = PSEL_IN & ~PENABLE_IN;
   wire apb_access = PSEL_IN & PENABLE_IN;
   wire apb_wr     = apb_access & PWRITE_IN;

   // one compare shared by write, read and error decode
   function addr_hit;
      input [11:0] a;
      input [11:0] ofs;
      begin
         addr_hit = (a == ofs);
      end
   endfunction

   // unmapped places answer with an error, not silence
   function mapped;
      input [11:0] a;
      begin
         mapped = addr_hit(a, `PSQ_CTRL_OFS) |
                  addr_hit(a, `PSQ_CFG_A_OFS) |
                  addr_hit(a, `PSQ_CFG_B_OFS) |
                  addr_hit(a, `PSQ_SERIAL_OFS) |
                  addr_hit(a, `PSQ_STATUS_OFS);
      end
   endfunction

   // no wait states, so ready is a constant
   assign PREADY_OUT  = 1'b1;
   assign PRDATA_OUT  = prdata_q;
   assign PSLVERR_OUT = pslverr_q & apb_access;

   // register writes; start bit does not stay set, it only arms a pulse
   always @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ctrl_q   <= `PSQ_CTRL_RST;
         cfg_a_q  <= `PSQ_CFG_A_RST;
         cfg_b_q  <= `PSQ_CFG_B_RST;
         serial_q <= `PSQ_SERIAL_RST;
         start_q  <= 1'b0;
      end else begin
         start_q <= 1'b0;
         if (apb_wr && addr_hit(PADDR_IN, `PSQ_CTRL_OFS)) begin
            ctrl_q  <= {PWDATA_IN[7:1], 1'b0};
            start_q <= PWDATA_IN[`PSQ_CTRL_START];
         end else if (apb_wr && addr_hit(PADDR_IN, `PSQ_CFG_A_OFS)) begin
            cfg_a_q <= PWDATA_IN;
         end else if (apb_wr && addr_hit(PADDR_IN, `PSQ_CFG_B_OFS)) begin
            cfg_b_q <= PWDATA_IN[15:0];
         end else if (apb_wr && addr_hit(PADDR_IN, `PSQ_SERIAL_OFS)) begin
            serial_q <= PWDATA_IN;
         end
      end
   end

   // read data captured in setup so it stands through the access phase
   always @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         prdata_q  <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else if (apb_setup) begin
         pslverr_q <= ~mapped(PADDR_IN);
         if (PWRITE_IN) begin
            prdata_q <= 32'h00000000;
         end else if (addr_hit(PADDR_IN, `PSQ_CTRL_OFS)) begin
            prdata_q <= {24'h000000, ctrl_q};
         end else if (addr_hit(PADDR_IN, `PSQ_CFG_A_OFS)) begin
            prdata_q <= cfg_a_q;
         end else if (addr_hit(PADDR_IN, `PSQ_CFG_B_OFS)) begin
            prdata_q <= {16'h0000, cfg_b_q};
         end else if (addr_hit(PADDR_IN, `PSQ_SERIAL_OFS)) begin
            prdata_q <= serial_q;
         end else if (addr_hit(PADDR_IN, `PSQ_STATUS_OFS)) begin
            // only the low byte of the count fits above the index
            prdata_q <= {tx_cnt_q[7:0], 3'h0, nib_q,
                         4'h0, rep_q, 5'h00, state_q};
         end else begin
            prdata_q <= 32'h00000000;
         end
      end
   end

   // two-stage synchroniser for the sync pin, edge taken after stage two
   always @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         sync_meta_q <= 1'b0;
         sync_s_q    <= 1'b0;
         sync_prev_q <= 1'b0;
      end else begin
         sync_meta_q <= SYNC_PULSE_IN;
         sync_s_q    <= sync_meta_q;
         sync_prev_q <= sync_s_q;
      end
   end

   // only stage two feeds the edge; stage one may be metastable
   wire sync_edge = sync_s_q & ~sync_prev_q;

   // slot timer for asynchronous mode, held at zero outside the run state
   wire timer_done = (timer_q == ASYNC_PERIOD_CYC - 13'h0001);

   always @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         timer_q <= 13'h0000;
      end else if (state_q != ST_RUN || timer_done) begin
         timer_q <= 13'h0000;
      end else begin
         timer_q <= timer_q + 13'h0001;
      end
   end

   // one transmission slot per sync pulse or per timer period
   wire slot = run_sync_q ? sync_edge : timer_done;
   // repetition count follows the mode latched at start
   wire [3:0] k_rep = run_sync_q ? `PSQ_K_SYNC : `PSQ_K_ASYNC;
   wire last_rep = (rep_q == k_rep - 4'h1);
   wire last_nib = (nib_q == 5'h1F);

   // data nibble for a given position in the stream
   function [3:0] nib_value;
      input [4:0] n;
      input       ext;
      input       ofs_ok;
      input       st_ok;
      reg   [3:0] v;
      reg         ok_o;
      reg         ok_s;
      begin
         v    = 4'h0;
         ok_o = ext & ofs_ok;
         ok_s = ext & st_ok;
         case (n)
            5'd0:  v = `PSQ_PROTO_REV;
            5'd1:  v = `PSQ_BLOCKS_HI;
            5'd2:  v = `PSQ_BLOCKS_LO;
            5'd3:  v = maker_code_field[7:4];
            5'd4:  v = maker_code_field[3:0];
            5'd5:  v = `PSQ_TYPE_HI;
            5'd6:  v = `PSQ_TYPE_LO;
            5'd7:  v = {dir_sel, 2'b00};
            5'd8:  v = `PSQ_RANGE_BASE + {2'b00, rng_sel};
            5'd9:  v = device_config_two[7:4];
            5'd10: v = device_config_two[3:0];
            5'd11: v = PROD_REV_HI;
            5'd12: v = PROD_REV_LO;
            5'd13: v = device_config_six[3:0];
            5'd14: v = julian_year[6:3];
            5'd15: v = {julian_year[2:0], julian_month[3]};
            5'd16: v = {julian_month[2:0], julian_day[4]};
            5'd17: v = julian_day[3:0];
            5'd18: v = serial_byte_zero[7:4];
            5'd19: v = serial_byte_zero[3:0];
            5'd20: v = serial_byte_one[7:4];
            5'd21: v = serial_byte_one[3:0];
            5'd22: v = serial_byte_two[7:4];
            5'd23: v = serial_byte_two[3:0];
            5'd24: v = serial_byte_three[7:4];
            5'd25: v = serial_byte_three[3:0];
            5'd26: v = ok_o ? RAW_OFFSET_IN[3:0] : 4'h0;
            5'd27: v = ok_o ? RAW_OFFSET_IN[7:4] : 4'h0;
            5'd28: v = {ok_s ? AVG_SELFTEST_IN[1:0] : 2'b00,
                        ok_o ? RAW_OFFSET_IN[9:8] : 2'b00};
            5'd29: v = ok_s ? AVG_SELFTEST_IN[5:2] : 4'h0;
            5'd30: v = ok_s ? AVG_SELFTEST_IN[9:6] : 4'h0;
            5'd31: v = ext ? device_config_one[7:4] : 4'h0;
            default: v = 4'h0;
         endcase
         nib_value = v;
      end
   endfunction

   // sequencer: id then data, k pairs per nibble, nibbles ascending
   always @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         state_q    <= ST_IDLE;
         nib_q      <= 5'h00;
         rep_q      <= 4'h0;
         is_data_q  <= 1'b0;
         tx_cnt_q   <= 10'h000;
         run_sync_q <= 1'b0;
         run_ext_q  <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE, ST_DONE: begin
               // mode is frozen for the whole phase so k cannot change
               if (start_q) begin
                  state_q    <= ST_RUN;
                  nib_q      <= 5'h00;
                  rep_q      <= 4'h0;
                  is_data_q  <= 1'b0;
                  tx_cnt_q   <= 10'h000;
                  run_sync_q <= sync_mode;
                  run_ext_q  <= ctrl_q[`PSQ_CTRL_EXT];
               end
            end
            ST_RUN: begin
               if (slot) begin
                  tx_cnt_q  <= tx_cnt_q + 10'h001;
                  is_data_q <= ~is_data_q;
                  if (is_data_q) begin
                     if (!last_rep) begin
                        rep_q <= rep_q + 4'h1;
                     end else if (!last_nib) begin
                        rep_q <= 4'h0;
                        nib_q <= nib_q + 5'h01;
                     end else begin
                        state_q <= ST_DONE;
                     end
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // stream outputs registered, one-cycle valid per slot
   always @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         TX_VALID_OUT    <= 1'b0;
         TX_NIBBLE_OUT   <= 4'h0;
         TX_IS_ID_OUT    <= 1'b0;
         PHASE2_DONE_OUT <= 1'b0;
      end else begin
         TX_VALID_OUT    <= (state_q == ST_RUN) & slot;
         PHASE2_DONE_OUT <= (state_q == ST_DONE);
         if (state_q == ST_RUN && slot) begin
            TX_IS_ID_OUT <= ~is_data_q;
            if (is_data_q) begin
               TX_NIBBLE_OUT <= nib_value(nib_q, run_ext_q,
                                          OFFSET_VALID_IN,
                                          SELFTEST_VALID_IN);
            end else begin
               TX_NIBBLE_OUT <= nib_q[3:0];
            end
         end
      end
   end

endmodule
`default_nettype wire

// [psq_rx_model.sv]
// receiver model: makes sync pulses and records the sensor's stream
// assumes the stream outputs are registered on the same clock
`timescale 1ns/1ns
`default_nettype none
module psq_rx_model (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   // control from the bench
   input  wire logic       sync_en_in,
   input  wire logic       clr_in,
   // stream from the sensor
   input  wire logic       tx_valid_in,
   input  wire logic [3:0] tx_nibble_in,
   input  wire logic       tx_is_id_in,
   // sync pulse to the sensor
   output logic            sync_out
);
   logic [3:0] tick_q;
   int         rx_cnt = 0;
   logic [3:0] nib_mem [0:511];
   logic       id_mem  [0:511];
   // 12-cycle period, 3 cycles high; pin rests low outside sync mode
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tick_q   <= 4'h0;
         sync_out <= 1'b0;
      end else begin
         tick_q   <= (tick_q == 4'hB) ? 4'h0 : tick_q + 4'h1;
         sync_out <= sync_en_in && (tick_q < 4'h3);
      end
   end
   // extra transmissions are counted but not stored
   always @(posedge clk_in) begin
      if (clr_in)
         rx_cnt <= 0;
      else if (tx_valid_in) begin
         if (rx_cnt < 512) begin
            nib_mem[rx_cnt] <= tx_nibble_in;
            id_mem[rx_cnt]  <= tx_is_id_in;
         end
         rx_cnt <= rx_cnt + 1;
      end
   end
endmodule
`default_nettype wire

// [psq_init2_seq_props.sv]
// stream checker, sees only the sequencer's top ports
// assumes start is not written again while a stream runs
`timescale 1ns/1ns
`default_nettype none
module psq_init2_seq_chk (
   // clock, reset and bus
   input wire logic        CLK_IN,
   input wire logic        RST_N_IN,
   input wire logic        PSEL_IN,
   input wire logic        PENABLE_IN,
   input wire logic        PWRITE_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   // stream
   input wire logic        TX_VALID_OUT,
   input wire logic [3:0]  TX_NIBBLE_OUT,
   input wire logic        TX_IS_ID_OUT,
   input wire logic        PHASE2_DONE_OUT
);
   logic        run_q;
   logic        sync_q;
   logic        ext_q;
   logic [10:0] cnt_q;
   wire         start = PSEL_IN & PENABLE_IN & PWRITE_IN & PWDATA_IN[0]
                        & (PADDR_IN == 12'h000);
   wire  [5:0]  nib = sync_q ? cnt_q[8:3] : cnt_q[9:4];
   wire         dat = TX_VALID_OUT & ~TX_IS_ID_OUT;
   // shadow of latched mode and of transmissions sent
   always @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         run_q  <= 1'b0;
         sync_q <= 1'b0;
         ext_q  <= 1'b0;
         cnt_q  <= 11'h000;
      end else if (start && !run_q) begin
         run_q  <= 1'b1;
         sync_q <= PWDATA_IN[1];
         ext_q  <= PWDATA_IN[2];
         cnt_q  <= 11'h000;
      end else begin
         if (TX_VALID_OUT)
            cnt_q <= cnt_q + 11'h001;
         if (PHASE2_DONE_OUT)
            run_q <= 1'b0;
      end
   end
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   chk_id_alternate: assert property (
      TX_VALID_OUT |-> TX_IS_ID_OUT == !cnt_q[0])
      else $error("identifier and data out of turn");
   chk_id_count: assert property (
      TX_VALID_OUT && TX_IS_ID_OUT |-> TX_NIBBLE_OUT == nib[3:0])
      else $error("identifier not the nibble count");
   chk_proto_rev: assert property (
      dat && nib == 6'h00 |-> TX_NIBBLE_OUT == 4'h4)
      else $error("protocol revision wrong");
   chk_block_count: assert property (
      dat && (nib == 6'h01 || nib == 6'h02)
      |-> TX_NIBBLE_OUT == (nib == 6'h01 ? 4'h2 : 4'h0))
      else $error("block count wrong");
   chk_sensor_type: assert property (
      dat && (nib == 6'h05 || nib == 6'h06)
      |-> TX_NIBBLE_OUT == {3'h0, nib == 6'h06})
      else $error("sensor type wrong");
   chk_ext_zero: assert property (
      dat && !ext_q && nib >= 6'h1A |-> TX_NIBBLE_OUT == 4'h0)
      else $error("extended nibble not zero");
   chk_done_total: assert property (
      $rose(PHASE2_DONE_OUT) |-> cnt_q + {10'h000, TX_VALID_OUT}
      == (sync_q ? 11'h100 : 11'h200))
      else $error("wrong transmission count at done");
   chk_valid_pulse: assert property (
      TX_VALID_OUT |=> !TX_VALID_OUT [*2])
      else $error("transmissions too close");
   chk_done_quiet: assert property (
      PHASE2_DONE_OUT |-> !TX_VALID_OUT)
      else $error("transmission after done");
   cov_sync_done: cover property ($rose(PHASE2_DONE_OUT) && sync_q);
   cov_async_done: cover property ($rose(PHASE2_DONE_OUT) && !sync_q);
   cov_ext_data: cover property (dat && ext_q && nib == 6'h1A
      && TX_NIBBLE_OUT != 4'h0);
endmodule
bind psq_init2_seq psq_init2_seq_chk chk_i (
   .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN),
   .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
   .PWDATA_IN(PWDATA_IN), .TX_VALID_OUT(TX_VALID_OUT),
   .TX_NIBBLE_OUT(TX_NIBBLE_OUT), .TX_IS_ID_OUT(TX_IS_ID_OUT),
   .PHASE2_DONE_OUT(PHASE2_DONE_OUT));
`default_nettype wire

// [test_psq_init2_seq.sv]
// self-checking bench for the phase 2 sequencer
// assumes the receiver model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module test_psq_init2_seq;
   localparam logic [3:0]  REV_HI = 4'h6; // arbitrary factory value
   localparam logic [3:0]  REV_LO = 4'h9; // arbitrary factory value
   localparam logic [31:0] CFG_A  = 32'h9D3B2CA5;
   localparam logic [15:0] CFG_B  = 16'hE7B6;
   localparam logic [31:0] SERIAL = 32'h89ABCDEF;
   localparam logic [9:0]  OFS    = 10'h2D3;
   localparam logic [9:0]  STV    = 10'h1B6;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, sync_en = 1'b0, rx_clr = 1'b0, vld = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd_q;
   logic pready, pslverr, sync, tx_valid, tx_id, done, er_q;
   logic [3:0] tx_nib;
   logic ext, vld_st = 1'b0;
   logic [1:0] dir, rng, vv;
   int err_total = 0, total_checks = 0, cyc = 0;
   psq_init2_seq #(.ASYNC_PERIOD_CYC(13'h0008), .PROD_REV_HI(REV_HI),
      .PROD_REV_LO(REV_LO)) uut (.CLK_IN(clk), .RST_N_IN(rst_n),
      .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
      .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SYNC_PULSE_IN(sync),
      .RAW_OFFSET_IN(OFS), .OFFSET_VALID_IN(vld), .AVG_SELFTEST_IN(STV),
      .SELFTEST_VALID_IN(vld_st), .TX_VALID_OUT(tx_valid),
      .TX_NIBBLE_OUT(tx_nib), .TX_IS_ID_OUT(tx_id),
      .PHASE2_DONE_OUT(done));
   psq_rx_model rx (.clk_in(clk), .rst_n_in(rst_n), .sync_en_in(sync_en),
      .clr_in(rx_clr), .tx_valid_in(tx_valid), .tx_nibble_in(tx_nib),
      .tx_is_id_in(tx_id), .sync_out(sync));
   always #20 clk = ~clk;
   // a hang ends the run as a mismatch
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total++;
         report_and_stop();
      end
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("CHECK FAILED t=%0t %s", $time, msg);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      chk(pready === 1'b1, "no bus answer");
      rd_q = prdata;
      er_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // data nibble expected at stream position n
   function automatic logic [3:0] exp_nib(input int n);
      logic [31:0] sn;
      logic [9:0]  o;
      logic [9:0]  s;
      o = (ext && vv[0]) ? OFS : 10'h000;
      s = (ext && vv[1]) ? STV : 10'h000;
      sn = SERIAL >> (8 * ((n - 18) / 2));
      case (n)
         0: return 4'h4;
         1: return 4'h2;
         3: return CFG_A[7:4];
         4: return CFG_A[3:0];
         6: return 4'h1;
         7: return {dir, 2'h0};
         8: return 4'h7 + {2'h0, rng};
         9: return CFG_A[23:20];
         10: return CFG_A[19:16];
         11: return REV_HI;
         12: return REV_LO;
         13: return CFG_A[27:24];
         14: return CFG_B[6:3];
         15: return {CFG_B[2:0], CFG_B[7]};
         16: return CFG_B[15:12];
         17: return CFG_B[11:8];
         26: return o[3:0];
         27: return o[7:4];
         28: return {s[1:0], o[9:8]};
         29: return s[5:2];
         30: return s[9:6];
         31: return ext ? CFG_A[15:12] : 4'h0;
         default: return (n >= 18 && n < 26) ?
            (n[0] ? sn[3:0] : sn[7:4]) : 4'h0;
      endcase
   endfunction
   // start one stream, let slots run on past done, compare all of it
   task automatic run(input logic s, input logic e, input logic [1:0] v,
                      input logic [1:0] d, input logic [1:0] r);
      int n;
      int m;
      int k;
      ext = e;
      vv = v;
      dir = d;
      rng = r;
      vld <= v[0];
      vld_st <= v[1];
      rx_clr <= 1'b1;
      @(posedge clk);
      rx_clr <= 1'b0;
      apb(1'b1, 12'h000, {24'h0, r, d, 1'b0, e, s, 1'b1});
      sync_en <= s;
      // done of the previous run falls only two edges after the write
      repeat (3) @(posedge clk);
      n = 0;
      while (done !== 1'b1 && n < 8000) begin
         @(posedge clk);
         n++;
      end
      chk(done === 1'b1, "done not raised");
      repeat (30) @(posedge clk);
      sync_en <= 1'b0;
      k = s ? 4 : 8;
      chk(rx.rx_cnt == 64 * k, "transmission count");
      for (n = 0; n < 64 * k; n++) begin
         m = n / (2 * k);
         chk(rx.id_mem[n] === !n[0], "id/data order");
         chk(rx.nib_mem[n] === (n[0] ? exp_nib(m) : m[3:0]),
             "nibble value");
      end
   endtask
   // reset values and an unmapped place
   task automatic t_reset_regs;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd_q === 32'h0 && er_q === 1'b0, "control reset value");
      apb(1'b0, 12'h004, 32'h0);
      chk(rd_q === 32'h0, "config reset value");
      apb(1'b0, 12'h010, 32'h0);
      chk(rd_q[2:0] === 3'h1, "status not idle");
      apb(1'b0, 12'h014, 32'h0);
      chk(er_q === 1'b1 && rd_q === 32'h0, "unmapped not refused");
   endtask
   task automatic t_load_cfg;
      apb(1'b1, 12'h004, CFG_A);
      apb(1'b1, 12'h008, {16'h0, CFG_B});
      apb(1'b1, 12'h00C, SERIAL);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd_q === CFG_A, "config readback");
   endtask
   // all axis and range codes; ext with each valid input alone
   task automatic t_sync_codes;
      for (int i = 0; i < 4; i++)
         run(1'b1, i[0], {i[1], i[1] ^ i[0]}, i[1:0],
             i[1:0]);
   endtask
   task automatic t_async;
      run(1'b0, 1'b1, 2'h3, 2'h1, 2'h2);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd_q[2:0] === 3'h4, "status not done");
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_regs();
      t_load_cfg();
      t_sync_codes();
      t_async();
      report_and_stop();
   end
endmodule
`default_nettype wire
